// ---- ima_consts.svh ----
`ifndef IMA_CONSTS_SVH
`define IMA_CONSTS_SVH

// ==========================================================
// register indices on the device port
`define IMA_IDX_VALUE      3'h0
`define IMA_IDX_ADDRESS    3'h1
`define IMA_IDX_COMMAND    3'h2
`define IMA_IDX_STATUS     3'h3
`define IMA_IDX_MODE       3'h4
`define IMA_IDX_LAST       3'h4

// ==========================================================
// field positions
`define IMA_CMD_READ_BIT   7
`define IMA_ADDR_DIR_BIT   7
`define IMA_MODE_SEL_HI    7
`define IMA_MODE_SEL_LO    6
`define IMA_STAT_PEND_BIT  0
`define IMA_MODE_RESET     8'h00

// ==========================================================
// access times (single accesses in half reference-clock cycles, sweeps in whole cycles), and cycle counts
`define IMA_T_NORMAL_X2    19
`define IMA_T_INIT_X2      5
`define IMA_T_CS_RESET     256
`define IMA_T_TS_ALL       1035
`define IMA_CYC_NORMAL     11'(`IMA_T_NORMAL_X2 / 2)
`define IMA_CYC_INIT       11'(`IMA_T_INIT_X2 / 2)
`define IMA_CYC_CS_RESET   11'(`IMA_T_CS_RESET)
`define IMA_CYC_TS_ALL     11'(`IMA_T_TS_ALL)

// ==========================================================
// axi response codes
`define IMA_AXI_RESP_OKAY  2'h0
`define IMA_AXI_RESP_ERR   2'h2

`endif

// ---- ima_pkg.sv ----
// ==========================================================
// shared types
package ima_pkg;
    typedef enum logic [1:0] {
        IMA_CS_RESET = 2'h0,
        IMA_BCAST    = 2'h1,
        IMA_CS_INIT  = 2'h2,
        IMA_NORMAL   = 2'h3
    } ima_mode_e;

    typedef enum logic [2:0] {
        IMA_IDLE = 3'b001,
        IMA_RUN  = 3'b010,
        IMA_DONE = 3'b100
    } ima_state_e;

    typedef logic [7:0] ima_byte_t;
endpackage : ima_pkg

// ---- ima_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// processor register port between controller and engine
interface ima_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic       reg_wr;
    logic       reg_rd;
    logic [2:0] reg_idx;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       busy;

    modport dev  (input aclk, aresetn, reg_wr, reg_rd, reg_idx, reg_wdata,
                  output reg_rdata, busy);
    modport host (input aclk, aresetn, reg_rdata, busy,
                  output reg_wr, reg_rd, reg_idx, reg_wdata);
endinterface : ima_if

`default_nettype wire

// ---- ima_engine.sv ----
// How it works
// - command write starts one memory operation
// - software leaves registers alone while busy
// - pending flag high during operation, else low
// - operations counted in reference clock cycles
// - normal single access within 9.5 cycles
// - mode field in top two bits, reset zero
// - reset mode sweeps control store, 256 cycles
// - modes 00 and 10 halt both interfaces
// - init mode single access within 2.5 cycles
// - normal mode: tristate sweep 1035 cycles
// - mode 01 sweeps all, ignores address
// - upstream store value resent every frame
// - operation code selects written bit group
// - upstream writes force direction bit high
// - upstream store readable for test
// - downstream store read-only, holds received data
// - read: address, command, poll, read value
// - data-store read returns all eight bits
// - idle code driven only where tristate enabled
// - software resets control store after reset
// - address bit 7 selects up or down
// - code 1100 writes timeslot tristate field
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ima_consts.svh"

module ima_engine
    import ima_pkg::*;
(
    // processor register port
    ima_if.dev         rp,
    // pcm transmit side
    input  wire logic [6:0] pcm_tx_slot,
    output logic      [7:0] pcm_tx_data,
    output logic      [7:0] pcm_tx_drive,
    // pcm receive side
    input  wire logic       pcm_rx_valid,
    input  wire logic [6:0] pcm_rx_slot,
    input  wire logic [7:0] pcm_rx_data,
    // interface enables
    output logic            ifaces_enabled
);

    // ==========================================================
    // registers and memories
    ima_byte_t   op_value;
    ima_byte_t   op_addr;
    ima_byte_t   op_cmd;
    ima_byte_t   op_mode;
    ima_state_e  state;
    logic [10:0] cnt;
    logic [8:0]  sweep_idx;
    logic        bcast;
    logic [7:0]  cs_data [256];
    logic [3:0]  cs_code [256];
    logic [7:0]  ds_up   [128];
    logic [3:0]  ds_ts   [128];
    logic [7:0]  ds_down [128];

    // ==========================================================
    // command decode
    ima_mode_e   mode;
    logic        launch;
    logic [3:0]  new_moc;
    logic        next_bcast;
    logic [10:0] next_dur;
    logic [3:0]  moc;
    logic        is_rd;
    logic        k_ds;
    logic        k_ts1;
    logic        k_tsall;
    logic        k_csd;
    logic        k_csb;
    logic [7:0]  eff_addr;
    logic [7:0]  ds_mask;
    logic        sweep_wr;
    logic        single_go;
    logic [7:0]  loc;

    assign mode    = ima_mode_e'(op_mode[`IMA_MODE_SEL_HI:`IMA_MODE_SEL_LO]);
    assign launch  = rp.reg_wr && (rp.reg_idx == `IMA_IDX_COMMAND)
                     && (state == IMA_IDLE);
    assign new_moc = rp.reg_wdata[6:3];
    assign moc     = op_cmd[6:3];
    assign is_rd   = op_cmd[`IMA_CMD_READ_BIT];
    assign k_ds    = !moc[3];
    assign k_ts1   = (moc == 4'hC);
    assign k_tsall = (moc == 4'hD);
    assign k_csd   = (moc == 4'h9);
    assign k_csb   = (moc[3:1] == 3'h7);

    // upstream data-store and tristate writes always target upstream
    assign eff_addr = (!is_rd && (k_ds || k_ts1))
                      ? {1'b1, op_addr[6:0]}
                      : op_addr;

    // mode 01 ignores the whole address for reads as well
    assign loc = (mode == IMA_BCAST) ? 8'h00 : eff_addr;

    // broadcast when the mode says so or for tristate reset
    always_comb begin
        next_bcast = 1'b0;
        next_dur   = `IMA_CYC_NORMAL;
        if (!rp.reg_wdata[`IMA_CMD_READ_BIT]) begin
            next_bcast = (rp.reg_wdata[6:3] == 4'hD)
                         || (op_mode[`IMA_MODE_SEL_LO] == 1'b0
                             && op_mode[`IMA_MODE_SEL_HI] == 1'b0)
                         || (ima_mode_e'(op_mode[7:6]) == IMA_BCAST);
        end
        if (next_bcast) begin
            next_dur = new_moc[3] && !new_moc[0] && !(new_moc == 4'h9)
                       ? `IMA_CYC_CS_RESET : `IMA_CYC_TS_ALL;
            if (new_moc[3:1] == 3'h7 || new_moc == 4'h9) begin
                next_dur = `IMA_CYC_CS_RESET;
            end else begin
                next_dur = `IMA_CYC_TS_ALL;
            end
        end else if (ima_mode_e'(op_mode[7:6]) == IMA_CS_INIT) begin
            next_dur = `IMA_CYC_INIT;
        end
    end

    // data-store write mask from the operation code
    always_comb begin
        case (moc)
            4'h1:    ds_mask = 8'hFF;
            4'h3:    ds_mask = 8'hF0;
            4'h2:    ds_mask = 8'h0F;
            4'h7:    ds_mask = 8'hC0;
            4'h6:    ds_mask = 8'h30;
            4'h5:    ds_mask = 8'h0C;
            4'h4:    ds_mask = 8'h03;
            default: ds_mask = 8'h00;
        endcase
    end

    // a sweep writes one location a cycle: the control store once, 128-entry stores in the first 128 of every 256 cycles
    assign sweep_wr  = (state == IMA_RUN) && bcast && !is_rd
                       && ((k_csd || k_csb) ? !sweep_idx[8] : !sweep_idx[7]);
    assign single_go = (state == IMA_RUN) && !bcast && (cnt == 11'h001);

    // ==========================================================
    // sequencer: pending lasts the whole access time
    always_ff @(posedge rp.aclk) begin
        if (!rp.aresetn) begin
            state     <= IMA_IDLE;
            cnt       <= 11'h000;
            sweep_idx <= 9'h000;
            bcast     <= 1'b0;
            op_cmd    <= 8'h00;
        end else begin
            case (state)
                IMA_IDLE: begin
                    if (launch) begin
                        op_cmd    <= rp.reg_wdata;
                        cnt       <= next_dur;
                        bcast     <= next_bcast;
                        sweep_idx <= 9'h000;
                        state     <= IMA_RUN;
                    end
                end
                IMA_RUN: begin
                    sweep_idx <= sweep_idx + 9'h001;
                    cnt       <= cnt - 11'h001;
                    if (cnt == 11'h001) begin
                        state <= IMA_DONE;
                    end
                end
                IMA_DONE: state <= IMA_IDLE;
                default:  state <= IMA_IDLE;
            endcase
        end
    end

    assign rp.busy = (state != IMA_IDLE);

    // ==========================================================
    // address and mode registers, frozen while busy
    always_ff @(posedge rp.aclk) begin
        if (!rp.aresetn) begin
            op_addr <= 8'h00;
            op_mode <= `IMA_MODE_RESET;
        end else if (rp.reg_wr && !rp.busy) begin
            if (rp.reg_idx == `IMA_IDX_ADDRESS) begin
                op_addr <= rp.reg_wdata;
            end else if (rp.reg_idx == `IMA_IDX_MODE) begin
                op_mode <= rp.reg_wdata;
            end
        end
    end

    // value register: software write or read result
    always_ff @(posedge rp.aclk) begin
        if (!rp.aresetn) begin
            op_value <= 8'h00;
        end else if (rp.reg_wr && !rp.busy && rp.reg_idx == `IMA_IDX_VALUE) begin
            op_value <= rp.reg_wdata;
        end else if (single_go && is_rd) begin
            if (k_ds) begin
                op_value <= loc[`IMA_ADDR_DIR_BIT] ? ds_up[loc[6:0]]
                                                   : ds_down[loc[6:0]];
            end else if (k_ts1) begin
                op_value <= {4'h0, ds_ts[loc[6:0]]};
            end else if (k_csd) begin
                op_value <= cs_data[loc];
            end else if (k_csb) begin
                op_value <= {4'h0, cs_code[loc]};
            end
        end
    end

    // ==========================================================
    // control store writes
    always_ff @(posedge rp.aclk) begin
        if (sweep_wr && (k_csd || k_csb)) begin
            cs_data[sweep_idx[7:0]] <= op_value;
            if (k_csb) begin
                cs_code[sweep_idx[7:0]] <= op_cmd[3:0];
            end
        end else if (single_go && !is_rd && (k_csd || k_csb)) begin
            cs_data[loc] <= op_value;
            if (k_csb) begin
                cs_code[loc] <= op_cmd[3:0];
            end
        end
    end

    // upstream data-store writes, masked by sub-timeslot
    always_ff @(posedge rp.aclk) begin
        if (sweep_wr && k_ds) begin
            ds_up[sweep_idx[6:0]] <= (ds_up[sweep_idx[6:0]] & ~ds_mask)
                                     | (op_value & ds_mask);
        end else if (single_go && !is_rd && k_ds) begin
            ds_up[loc[6:0]] <= (ds_up[loc[6:0]] & ~ds_mask) | (op_value & ds_mask);
        end
    end

    // tristate field writes
    always_ff @(posedge rp.aclk) begin
        if (sweep_wr && (k_tsall || k_ts1)) begin
            ds_ts[sweep_idx[6:0]] <= op_value[3:0];
        end else if (single_go && !is_rd && k_ts1) begin
            ds_ts[loc[6:0]] <= op_value[3:0];
        end
    end

    // downstream store is only ever written by the receiver
    always_ff @(posedge rp.aclk) begin
        if (pcm_rx_valid && ifaces_enabled) begin
            ds_down[pcm_rx_slot] <= pcm_rx_data;
        end
    end

    // ==========================================================
    // register read port
    always_ff @(posedge rp.aclk) begin
        if (!rp.aresetn) begin
            rp.reg_rdata <= 8'h00;
        end else if (rp.reg_rd) begin
            if (rp.reg_idx == `IMA_IDX_VALUE) begin
                rp.reg_rdata <= op_value;
            end else if (rp.reg_idx == `IMA_IDX_ADDRESS) begin
                rp.reg_rdata <= op_addr;
            end else if (rp.reg_idx == `IMA_IDX_COMMAND) begin
                rp.reg_rdata <= op_cmd;
            end else if (rp.reg_idx == `IMA_IDX_STATUS) begin
                rp.reg_rdata <= {7'h00, rp.busy};
            end else if (rp.reg_idx == `IMA_IDX_MODE) begin
                rp.reg_rdata <= op_mode;
            end else begin
                rp.reg_rdata <= 8'h00;
            end
        end
    end

    // ==========================================================
    // pcm transmit: stored code resent each frame where enabled
    assign ifaces_enabled = op_mode[`IMA_MODE_SEL_LO];

    logic [7:0] drive_exp;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sub
            assign drive_exp[2*g+1:2*g] = {2{ds_ts[pcm_tx_slot][g]}};
        end
    endgenerate

    always_ff @(posedge rp.aclk) begin
        if (!rp.aresetn) begin
            pcm_tx_data  <= 8'h00;
            pcm_tx_drive <= 8'h00;
        end else begin
            pcm_tx_data  <= ds_up[pcm_tx_slot];
            pcm_tx_drive <= ifaces_enabled ? drive_exp : 8'h00;
        end
    end

endmodule : ima_engine

`default_nettype wire

// ---- ima_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ima_consts.svh"

// ==========================================================
// axi4-lite controller driving the engine's register port
module ima_ctrl
    import ima_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi write channels
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi read channels
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // engine port
    ima_if.host              rp
);

    // ==========================================================
    // write path
    logic        aw_got;
    logic        w_got;
    logic [2:0]  w_idx;
    logic [7:0]  w_byte;
    logic        w_en;
    logic        w_hold;
    logic        w_mapped;
    logic        rd_go;
    logic [2:0]  r_idx;
    logic [1:0]  r_phase;

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign w_mapped      = (w_idx <= `IMA_IDX_LAST);
    // engine registers other than mode wait for the engine to go idle
    assign w_hold        = rp.busy && (w_idx != `IMA_IDX_MODE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            w_idx        <= 3'h0;
            w_byte       <= 8'h00;
            w_en         <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `IMA_AXI_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                w_idx  <= s_axi_awaddr[4:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got  <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_en   <= s_axi_wstrb[0];
            end
            if (aw_got && w_got && !w_hold && !rd_go) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_mapped ? `IMA_AXI_RESP_OKAY : `IMA_AXI_RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read path: strobe, wait for the engine's registered data
    assign s_axi_arready = (r_phase == 2'h0) && !s_axi_rvalid;
    assign rd_go         = (r_phase == 2'h1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_phase      <= 2'h0;
            r_idx        <= 3'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `IMA_AXI_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                r_idx   <= s_axi_araddr[4:2];
                r_phase <= 2'h1;
            end else if (r_phase == 2'h1) begin
                // value reads wait for the running operation to finish
                if (!(rp.busy && r_idx == `IMA_IDX_VALUE)) begin
                    r_phase <= 2'h2;
                end
            end else if (r_phase == 2'h2) begin
                r_phase      <= 2'h0;
                s_axi_rvalid <= 1'b1;
                // unmapped indices read as zero, not the last engine byte
                s_axi_rdata  <= (r_idx <= `IMA_IDX_LAST) ? {24'h000000, rp.reg_rdata}
                                                         : 32'h0000_0000;
                s_axi_rresp  <= (r_idx <= `IMA_IDX_LAST) ? `IMA_AXI_RESP_OKAY
                                                         : `IMA_AXI_RESP_ERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // engine strobes, one cycle each
    always_comb begin
        rp.reg_wr    = aw_got && w_got && !w_hold && !rd_go && w_en && w_mapped;
        rp.reg_rd    = rd_go && (r_idx <= `IMA_IDX_LAST)
                       && !(rp.busy && r_idx == `IMA_IDX_VALUE);
        rp.reg_idx   = rd_go ? r_idx : w_idx;
        rp.reg_wdata = w_byte;
    end

endmodule : ima_ctrl

`default_nettype wire

// ---- ima_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// register port checker
module ima_properties (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [2:0] reg_idx,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       busy
);
    logic [1:0]  mode;
    logic [1:0]  cmd_mode;
    logic [7:0]  cmd;
    logic [10:0] blen;
    logic        sweep;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // helpers
    // shadow of the mode field and of the launching command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= 2'h0;
            cmd_mode <= 2'h0;
            cmd <= 8'h00;
        end else if (reg_wr && reg_idx == 3'h4) begin
            mode <= reg_wdata[7:6];
        end else if (reg_wr && reg_idx == 3'h2 && !busy) begin
            cmd <= reg_wdata;
            cmd_mode <= mode;
        end
    end
    // length of the busy run, read where busy falls
    always_ff @(posedge aclk) begin
        if (!aresetn || !busy) begin
            blen <= 11'h000;
        end else begin
            blen <= blen + 11'h001;
        end
    end
    // write to every tristate field
    assign sweep = !cmd[7] && cmd[6:3] == 4'hD;

    // ==========================================================
    // assertions
    a_cmd_launch:
        assert property (reg_wr && reg_idx == 3'h2 && !busy |=> busy)
        else $error("command write started nothing");
    a_rise_cause:
        assert property ($rose(busy) |-> $past(reg_wr) && $past(reg_idx) == 3'h2)
        else $error("busy rose without a command");
    a_min_busy:
        assert property ($rose(busy) |-> busy[*3])
        else $error("busy run too short");
    a_normal_time:
        assert property ($fell(busy) && cmd_mode == 2'h3 && !sweep |-> blen == 11'h00A)
        else $error("normal access length wrong");
    a_init_time:
        assert property ($fell(busy) && cmd_mode == 2'h2 && !sweep |-> blen == 11'h003)
        else $error("init access length wrong");
    a_sweep_time:
        assert property ($fell(busy) && cmd_mode == 2'h3 && sweep |-> blen == 11'h40C)
        else $error("tristate sweep length wrong");
    a_cs_reset_time:
        assert property ($fell(busy) && cmd_mode == 2'h0 && cmd == 8'h70 |-> blen == 11'h101)
        else $error("control store sweep length wrong");
    a_status_bit:
        assert property (reg_rd && reg_idx == 3'h3 |=> reg_rdata[0] == $past(busy))
        else $error("status bit differs from busy");
endmodule : ima_properties

`default_nettype wire

// ---- test_indirect_memory_access_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ima_consts.svh"

// ==========================================================
// controller and engine joined at the register port
module test_indirect_memory_access_engine;
    logic        aclk, aresetn, aw_valid, aw_ready, w_valid, w_ready, b_valid;
    logic        ar_valid, ar_ready, r_valid, rx_valid, ifaces_on;
    logic [1:0]  b_resp, r_resp, resp;
    logic [4:0]  aw_addr, ar_addr;
    logic [6:0]  tx_slot, rx_slot;
    logic [7:0]  tx_data, tx_drive, rx_data, exp_val;
    logic [31:0] w_data, r_data, rd_val;
    int          miscompares, samples_checked, cycles;
    localparam logic [3:0] op_tab [8] = '{4'h1, 4'h3, 4'h2, 4'h7, 4'h6, 4'h5, 4'h4, 4'h0};
    localparam logic [7:0] msk_tab [8] = '{8'hFF, 8'hF0, 8'h0F, 8'hC0, 8'h30, 8'h0C, 8'h03, 8'h00};

    // ==========================================================
    // design, carrier and checker
    ima_if ima_if_i (.aclk(aclk), .aresetn(aresetn));
    ima_ctrl ima_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .rp(ima_if_i),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid),
        .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
        .s_axi_bready(1'b1), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
        .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_valid), .s_axi_rready(1'b1));
    ima_engine ima_engine_i (
        .rp(ima_if_i), .pcm_tx_slot(tx_slot), .pcm_tx_data(tx_data),
        .pcm_tx_drive(tx_drive), .pcm_rx_valid(rx_valid), .pcm_rx_slot(rx_slot),
        .pcm_rx_data(rx_data), .ifaces_enabled(ifaces_on));
    ima_properties ima_properties_i (
        .aclk(aclk), .aresetn(aresetn), .reg_wr(ima_if_i.reg_wr),
        .reg_rd(ima_if_i.reg_rd), .reg_idx(ima_if_i.reg_idx),
        .reg_wdata(ima_if_i.reg_wdata), .reg_rdata(ima_if_i.reg_rdata),
        .busy(ima_if_i.busy));

    // ==========================================================
    // tasks
    // verdict and end of run
    task automatic test_done;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // axi write, address and data offered together
    task automatic axi_wr(input logic [2:0] idx, input logic [7:0] val, output logic [1:0] rsp);
        aw_addr <= {idx, 2'h0};
        w_data <= {24'h0, val};
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
        end while ((aw_valid && !aw_ready) || (w_valid && !w_ready));
        do @(posedge aclk); while (!b_valid);
        rsp = b_resp;
    endtask : axi_wr
    // axi read
    task automatic axi_rd(input logic [2:0] idx, output logic [31:0] val, output logic [1:0] rsp);
        ar_addr <= {idx, 2'h0};
        ar_valid <= 1'b1;
        do @(posedge aclk); while (!ar_ready);
        ar_valid <= 1'b0;
        do @(posedge aclk); while (!r_valid);
        val = r_data;
        rsp = r_resp;
    endtask : axi_rd
    // value, address, command, then poll the pending flag
    task automatic mem_op(input logic [7:0] val, input logic [7:0] adr, input logic [7:0] cmd);
        axi_wr(`IMA_IDX_VALUE, val, resp);
        axi_wr(`IMA_IDX_ADDRESS, adr, resp);
        axi_wr(`IMA_IDX_COMMAND, cmd, resp);
        rd_val = 32'h1;
        while (rd_val[0] !== 1'b0) begin
            axi_rd(`IMA_IDX_STATUS, rd_val, resp);
        end
    endtask : mem_op
    // memory read through the value register
    task automatic mem_rd(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] exp);
        mem_op(8'h00, adr, cmd);
        axi_rd(`IMA_IDX_VALUE, rd_val, resp);
        chk("memory value", rd_val, {24'h0, exp});
    endtask : mem_rd

    // ==========================================================
    // clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    // ==========================================================
    // test sequence
    initial begin
        {miscompares, samples_checked, cycles} = '0;
        {aresetn, aw_valid, w_valid, ar_valid, rx_valid, aw_addr, ar_addr} = '0;
        {w_data, rx_slot, rx_data} = '0;
        tx_slot = 7'h40;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(`IMA_IDX_MODE, rd_val, resp);
        chk("mode at reset", rd_val, 32'h0);
        chk("ifaces at reset", {31'h0, ifaces_on}, 32'h0);
        mem_op(8'h5A, 8'h00, 8'h70);
        axi_wr(`IMA_IDX_MODE, 8'h80, resp);
        chk("ifaces in init", {31'h0, ifaces_on}, 32'h0);
        mem_rd(8'h10, 8'hC8, 8'h5A);
        mem_op(8'h3C, 8'h85, 8'h48);
        mem_rd(8'h85, 8'hC8, 8'h3C);
        axi_wr(`IMA_IDX_MODE, 8'hC0, resp);
        axi_rd(`IMA_IDX_MODE, rd_val, resp);
        chk("mode value", rd_val, 32'hC0);
        chk("ifaces in normal", {31'h0, ifaces_on}, 32'h1);
        mem_op(8'h00, 8'h00, 8'h68);
        mem_op(8'hA5, 8'h40, 8'h08);
        mem_op(8'h09, 8'hC0, 8'h60);
        repeat (3) @(posedge aclk);
        chk("tx data", {24'h0, tx_data}, 32'hA5);
        chk("tx drive", {24'h0, tx_drive}, 32'hC3);
        mem_rd(8'hC0, 8'hB8, 8'hA5);
        // every bit group in turn, each write flipping only its group
        exp_val = 8'hA5;
        for (int i = 0; i < 8; i++) begin
            mem_op(~exp_val, 8'hC0, {1'b0, op_tab[i], 3'h0});
            exp_val = exp_val ^ msk_tab[i];
            mem_rd(8'hC0, 8'h80, exp_val);
        end
        // received byte lands downstream, writes go upstream
        rx_slot <= 7'h05;
        rx_data <= 8'h3C;
        rx_valid <= 1'b1;
        @(posedge aclk);
        rx_valid <= 1'b0;
        mem_op(8'h11, 8'h05, 8'h08);
        mem_rd(8'h05, 8'h80, 8'h3C);
        mem_rd(8'h85, 8'h80, 8'h11);
        axi_wr(`IMA_IDX_MODE, 8'h40, resp);
        mem_op(8'h77, 8'h05, 8'h08);
        axi_wr(`IMA_IDX_MODE, 8'hC0, resp);
        mem_rd(8'hC0, 8'h80, 8'h77);
        axi_wr(3'h5, 8'hFF, resp);
        chk("unmapped write", {30'h0, resp}, {30'h0, `IMA_AXI_RESP_ERR});
        axi_rd(3'h5, rd_val, resp);
        chk("unmapped read", rd_val, 32'h0);
        chk("unmapped read resp", {30'h0, resp}, {30'h0, `IMA_AXI_RESP_ERR});
        test_done();
    end
endmodule : test_indirect_memory_access_engine

`default_nettype wire
